// *** mcr_config_regs.sv ***
/*
 * Miscellaneous chip configuration register bank: watchdog fire tally,
 * reference-pin disable, lockable I/O bank rail level, strap status.
 * Assumes a single-cycle register port driven from clk_sys, with read data
 * returned in the cycle after the read strobe, and a reset controller that
 * tells on resetByWatchdog whether the current srst came from the watchdog.
 * The strap status word trails the strap pin by two clocks, the price of
 * synchronising a pin that may move at any time.
 */
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Tally clears on power-on, survives watchdog reset
// - Bit 0 set disables reference pin function
// - Rail bits and lock writable until locked
// - Lock cannot be cleared until reset
// - Bank-2 level bit: 1=1.8V, 0=3.3V
module mcr_config_regs (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        resetByWatchdog,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output var  logic [31:0] regRdData,
	input  wire logic        bank2RailStrap,
	output var  logic [3:0]  watchdogFireTally,
	output var  logic        cpuVrefPinOff,
	output var  logic        cpuVrefPinEnable,
	output var  logic        bank2RailLevel,
	output var  logic        railTestBit,
	output var  logic        railLevelLocked
);

	typedef enum logic [3:0] {
		SEL_TALLY  = 4'b0001,
		SEL_VREF   = 4'b0010,
		SEL_RAIL   = 4'b0100,
		SEL_STRAP  = 4'b1000
	} mcr_select_type;

	typedef struct packed {
		logic [3:0]  tally;
		logic        vrefOff;
		logic        vrefEnable;
		logic [31:0] rdData;
	} mcr_bank_state_type;

	mcr_bank_state_type state;
	mcr_bank_state_type next_state;

	logic [2:0] railLevel;
	logic       railLocked;
	logic       strapLevel;
	logic       railWrite;

	// One-hot select for an address; zero for any unmapped offset
	function automatic logic [3:0] decodeSelect(input logic [7:0] addr);
		logic [3:0] sel;
		sel = 4'h0;
		case (addr)
			mcr_pkg::OFFSET_WATCHDOG_FIRE_TALLY: begin
				sel = SEL_TALLY;
			end
			mcr_pkg::OFFSET_CPU_VREF_PIN_DISABLE: begin
				sel = SEL_VREF;
			end
			mcr_pkg::OFFSET_IO_BANK_RAIL_LEVEL: begin
				sel = SEL_RAIL;
			end
			mcr_pkg::OFFSET_RAIL_STRAP_STATUS: begin
				sel = SEL_STRAP;
			end
			default: begin
				sel = 4'h0;
			end
		endcase
		return sel;
	endfunction : decodeSelect

	// Rail level word as software sees it; spare bits stay zero
	function automatic logic [31:0] railWord(
		input logic [2:0] level,
		input logic       lock
	);
		logic [31:0] word;
		word = 32'h0000_0000;
		word[mcr_pkg::RAIL_LEVEL_LSB +: mcr_pkg::RAIL_LEVEL_WIDTH] = level;
		word[mcr_pkg::RAIL_LOCK_BIT] = lock;
		return word;
	endfunction : railWord

	// Strap status word: synchronised strap and its mismatch with bank-2 level
	function automatic logic [31:0] strapWord(
		input logic strap,
		input logic level2
	);
		logic [31:0] word;
		word = 32'h0000_0000;
		word[mcr_pkg::STRAP_LEVEL_BIT]    = strap;
		word[mcr_pkg::STRAP_MISMATCH_BIT] = strap ^ level2;
		return word;
	endfunction : strapWord

	// True when a strobe hits the given register; shared by every write path
	function automatic logic strobeHits(
		input logic           strobe,
		input logic [7:0]     addr,
		input mcr_select_type target
	);
		logic hit;
		hit = 1'b0;
		if (strobe) begin
			hit = (decodeSelect(addr) == target);
		end
		return hit;
	endfunction : strobeHits

	// Tally word: four stored bits, reserved bits read as zero
	function automatic logic [31:0] tallyWord(
		input logic [3:0] tally
	);
		logic [31:0] word;
		word = 32'h0000_0000;
		word[mcr_pkg::TALLY_LSB +: mcr_pkg::TALLY_WIDTH] = tally;
		return word;
	endfunction : tallyWord

	// Reference-pin word: one stored bit, reserved bits read as zero
	function automatic logic [31:0] vrefWord(
		input logic off
	);
		logic [31:0] word;
		word = 32'h0000_0000;
		word[mcr_pkg::VREF_OFF_BIT] = off;
		return word;
	endfunction : vrefWord

	// Pin function is the inverse of the disable bit, whatever the pin mux says
	function automatic logic pinEnabled(
		input logic off
	);
		logic enabled;
		enabled = !off;
		return enabled;
	endfunction : pinEnabled

	// Write-data fields; reserved bits are dropped here and nowhere else
	function automatic logic [3:0] tallyField(
		input logic [31:0] data
	);
		logic [3:0] field;
		field = data[mcr_pkg::TALLY_LSB +: mcr_pkg::TALLY_WIDTH];
		return field;
	endfunction : tallyField

	function automatic logic vrefOffField(
		input logic [31:0] data
	);
		logic field;
		field = data[mcr_pkg::VREF_OFF_BIT];
		return field;
	endfunction : vrefOffField

	function automatic logic [2:0] railLevelField(
		input logic [31:0] data
	);
		logic [2:0] field;
		field = data[mcr_pkg::RAIL_LEVEL_LSB +: mcr_pkg::RAIL_LEVEL_WIDTH];
		return field;
	endfunction : railLevelField

	function automatic logic railLockField(
		input logic [31:0] data
	);
		logic field;
		field = data[mcr_pkg::RAIL_LOCK_BIT];
		return field;
	endfunction : railLockField

	// Tally after a reset: a watchdog reset keeps it, any other reset clears it
	function automatic logic [3:0] tallyAfterReset(
		input logic [3:0] tally,
		input logic       byWatchdog
	);
		logic [3:0] kept;
		kept = mcr_pkg::TALLY_RESET;
		if (byWatchdog) begin
			kept = tally;
		end
		return kept;
	endfunction : tallyAfterReset

	// Read mux; unmapped offsets answer zero so a stray read never stalls
	function automatic logic [31:0] readWord(
		input logic [3:0] sel,
		input logic [3:0] tally,
		input logic       off,
		input logic [2:0] level,
		input logic       lock,
		input logic       strap
	);
		logic [31:0] word;
		word = mcr_pkg::READ_IDLE;
		case (sel)
			SEL_TALLY: begin
				word = tallyWord(tally);
			end
			SEL_VREF: begin
				word = vrefWord(off);
			end
			SEL_RAIL: begin
				word = railWord(level, lock);
			end
			SEL_STRAP: begin
				word = strapWord(strap, level[mcr_pkg::RAIL_BANK2_BIT]);
			end
			default: begin
				word = mcr_pkg::READ_IDLE;
			end
		endcase
		return word;
	endfunction : readWord

	// Strap pin comes from outside the clock domain
	mcr_sync2 u_strap_sync (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.pinLevel  (bank2RailStrap),
		.syncLevel (strapLevel)
	);

	assign railWrite = strobeHits(regWr, regAddr, SEL_RAIL);

	// Test bit and bank-2 level live in the low rail bits; bit 7 locks them
	mcr_lock_field #(
		.WIDTH (mcr_pkg::RAIL_LEVEL_WIDTH)
	) u_rail_lock (
		.clk_sys    (clk_sys),
		.srst       (srst),
		.wrEn       (railWrite),
		.wrValue    (railLevelField(regWrData)),
		.wrLock     (railLockField(regWrData)),
		.fieldValue (railLevel),
		.locked     (railLocked)
	);

	always_comb begin
		next_state = state;

		// Tally simply stores what firmware writes; no hardware increment
		if (strobeHits(regWr, regAddr, SEL_TALLY)) begin
			next_state.tally = tallyField(regWrData);
		end

		if (strobeHits(regWr, regAddr, SEL_VREF)) begin
			next_state.vrefOff = vrefOffField(regWrData);
		end
		// Pin function follows the bit alone, regardless of pin mux
		next_state.vrefEnable = pinEnabled(next_state.vrefOff);

		// Read data stand only in the cycle after the strobe
		next_state.rdData = mcr_pkg::READ_IDLE;
		if (regRd) begin
			next_state.rdData = readWord(decodeSelect(regAddr), state.tally, state.vrefOff,
				railLevel, railLocked, strapLevel);
		end

		if (srst) begin
			next_state.vrefOff    = mcr_pkg::VREF_OFF_RESET;
			next_state.vrefEnable = pinEnabled(mcr_pkg::VREF_OFF_RESET);
			next_state.rdData     = mcr_pkg::READ_IDLE;
			// Watchdog resets keep the tally so firmware can count them
			next_state.tally = tallyAfterReset(state.tally, resetByWatchdog);
		end
	end

	always_ff @(posedge clk_sys) begin
		state <= next_state;
	end

	// Outputs come straight from flip-flops here and in the submodules
	always_comb begin
		regRdData         = state.rdData;
		watchdogFireTally = state.tally;
		cpuVrefPinOff     = state.vrefOff;
		cpuVrefPinEnable  = state.vrefEnable;
		bank2RailLevel    = railLevel[mcr_pkg::RAIL_BANK2_BIT];
		railTestBit       = railLevel[mcr_pkg::RAIL_TEST_BIT];
		railLevelLocked   = railLocked;
	end

endmodule : mcr_config_regs

`default_nettype wire

// *** mcr_pkg.sv ***
/*
 * Shared constants for the miscellaneous chip configuration register bank:
 * register offsets, field positions, widths and values after reset.
 * Assumes byte addresses on an 8-bit register port with 32-bit data.
 */
`default_nettype none

package mcr_pkg;

	localparam int unsigned ADDR_WIDTH = 8;
	localparam int unsigned DATA_WIDTH = 32;

	// Register offsets (byte addresses, one aligned word each)
	localparam logic [7:0] OFFSET_WATCHDOG_FIRE_TALLY  = 8'h28;
	localparam logic [7:0] OFFSET_CPU_VREF_PIN_DISABLE = 8'h40;
	localparam logic [7:0] OFFSET_IO_BANK_RAIL_LEVEL   = 8'h64;
	localparam logic [7:0] OFFSET_RAIL_STRAP_STATUS    = 8'h68;

	// Watchdog fire tally field
	localparam int unsigned TALLY_LSB   = 0;
	localparam int unsigned TALLY_WIDTH = 4;
	localparam logic [3:0]  TALLY_RESET = 4'h0;

	// Reference-pin disable field
	localparam int unsigned VREF_OFF_BIT   = 0;
	localparam logic        VREF_OFF_RESET = 1'h0;

	// Rail level register fields
	localparam int unsigned RAIL_TEST_BIT    = 0;
	localparam int unsigned RAIL_BANK2_BIT   = 1;
	localparam int unsigned RAIL_LEVEL_LSB   = 0;
	localparam int unsigned RAIL_LEVEL_WIDTH = 3;
	localparam int unsigned RAIL_LOCK_BIT    = 7;
	localparam logic [2:0]  RAIL_LEVEL_RESET = 3'h0;
	localparam logic        RAIL_LOCK_RESET  = 1'h0;

	// Strap status register fields
	localparam int unsigned STRAP_LEVEL_BIT    = 0;
	localparam int unsigned STRAP_MISMATCH_BIT = 1;

	// Read data outside a read's answer cycle
	localparam logic [31:0] READ_IDLE = 32'h0000_0000;

endpackage : mcr_pkg

`default_nettype wire

// *** mcr_sync2.sv ***
/*
 * Two-flop synchroniser for a single level from a pin.
 * Assumes the level changes slowly compared with clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

module mcr_sync2 (
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic pinLevel,
	output var  logic syncLevel
);

	typedef struct packed {
		logic stage1;
		logic stage2;
	} mcr_sync_state_type;

	mcr_sync_state_type state;
	mcr_sync_state_type next_state;

	// Stage one feeds stage two only; nothing else looks at it
	always_comb begin
		next_state = state;
		next_state.stage1 = pinLevel;
		next_state.stage2 = state.stage1;
		if (srst) begin
			next_state = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		state <= next_state;
	end

	assign syncLevel = state.stage2;

endmodule : mcr_sync2

`default_nettype wire

// *** mcr_lock_field.sv ***
/*
 * Lockable field: a group of value bits plus a lock bit that, once set,
 * freezes both until the next system reset.
 * Assumes write strobes are one clk_sys cycle long.
 */
`timescale 1ns/10ps
`default_nettype none

module mcr_lock_field #(
	parameter int unsigned WIDTH = 3
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic             wrEn,
	input  wire logic [WIDTH-1:0] wrValue,
	input  wire logic             wrLock,
	output var  logic [WIDTH-1:0] fieldValue,
	output var  logic             locked
);

	typedef struct packed {
		logic [WIDTH-1:0] value;
		logic             lock;
	} mcr_lock_state_type;

	mcr_lock_state_type state;
	mcr_lock_state_type next_state;

	always_comb begin
		next_state = state;
		// Writes land only while unlocked; lock is sticky so a zero is ignored
		if (wrEn && !state.lock) begin
			next_state.value = wrValue;
			next_state.lock  = wrLock;
		end
		if (srst) begin
			next_state.value = WIDTH'(mcr_pkg::RAIL_LEVEL_RESET);
			next_state.lock  = mcr_pkg::RAIL_LOCK_RESET;
		end
	end

	always_ff @(posedge clk_sys) begin
		state <= next_state;
	end

	assign fieldValue = state.value;
	assign locked     = state.lock;

endmodule : mcr_lock_field

`default_nettype wire

// *** mcr_config_regs_props.sv ***
/* Port checker for mcr_config_regs.
 Assumes one clk_sys domain; bound to the bank below. */
`timescale 1ns/10ps
`default_nettype none
module mcr_config_regs_props (
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire logic        resetByWatchdog,
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWrData,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdData,
	input wire logic        bank2RailStrap,
	input wire logic [3:0]  watchdogFireTally,
	input wire logic        cpuVrefPinOff,
	input wire logic        cpuVrefPinEnable,
	input wire logic        bank2RailLevel,
	input wire logic        railTestBit,
	input wire logic        railLevelLocked
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Reset checks must see srst itself
	property p_tallyPor; disable iff (1'b0) srst && !resetByWatchdog |=> watchdogFireTally == 4'h0; endproperty
	a_tallyPor: assert property (p_tallyPor) else $error("tally not cleared");
	property p_tallyWdt; disable iff (1'b0) srst && resetByWatchdog |=> $stable(watchdogFireTally); endproperty
	a_tallyWdt: assert property (p_tallyWdt) else $error("tally lost");
	property p_vrefPair; cpuVrefPinEnable == !cpuVrefPinOff; endproperty
	a_vrefPair: assert property (p_vrefPair) else $error("pin enable wrong");
	property p_vrefWr; regWr && regAddr == 8'h40 |=> cpuVrefPinOff == $past(regWrData[0]); endproperty
	a_vrefWr: assert property (p_vrefWr) else $error("pin off not written");
	property p_railWr;
		regWr && regAddr == 8'h64 && !railLevelLocked |=>
			bank2RailLevel == $past(regWrData[1]) && railTestBit == $past(regWrData[0]) &&
			railLevelLocked == $past(regWrData[7]);
	endproperty
	a_railWr: assert property (p_railWr) else $error("rail not written");
	property p_lockHold; railLevelLocked |=> railLevelLocked; endproperty
	a_lockHold: assert property (p_lockHold) else $error("lock cleared");
	property p_lockFreeze; railLevelLocked |=> $stable({bank2RailLevel, railTestBit}); endproperty
	a_lockFreeze: assert property (p_lockFreeze) else $error("locked rail changed");
	property p_rdTally; regRd && regAddr == 8'h28 |=> regRdData == {28'h0, watchdogFireTally}; endproperty
	a_rdTally: assert property (p_rdTally) else $error("tally read wrong");
	property p_rdIdle; !regRd |=> regRdData == 32'h0; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
	property p_rdRail;
		regRd && regAddr == 8'h64 |=>
			regRdData[1:0] == {bank2RailLevel, railTestBit} && regRdData[7] == railLevelLocked &&
			regRdData[31:8] == 24'h0 && regRdData[6:3] == 4'h0;
	endproperty
	a_rdRail: assert property (p_rdRail) else $error("rail read wrong");
endmodule : mcr_config_regs_props
bind mcr_config_regs mcr_config_regs_props u_props (
	.clk_sys           (clk_sys),
	.srst              (srst),
	.resetByWatchdog   (resetByWatchdog),
	.regAddr           (regAddr),
	.regWrData         (regWrData),
	.regWr             (regWr),
	.regRd             (regRd),
	.regRdData         (regRdData),
	.bank2RailStrap    (bank2RailStrap),
	.watchdogFireTally (watchdogFireTally),
	.cpuVrefPinOff     (cpuVrefPinOff),
	.cpuVrefPinEnable  (cpuVrefPinEnable),
	.bank2RailLevel    (bank2RailLevel),
	.railTestBit       (railTestBit),
	.railLevelLocked   (railLevelLocked)
);
`default_nettype wire

// *** test_mcr_config_regs.sv ***
/* Register-level bench for mcr_config_regs.
 Assumes the single-cycle register port; drives every input itself. */
`timescale 1ns/10ps
`default_nettype none
module test_mcr_config_regs;
	logic        clk_sys = 1'b0, srst = 1'b1, resetByWatchdog = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic        bank2RailStrap = 1'b1;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0, regRdData;
	logic [3:0]  watchdogFireTally;
	logic        cpuVrefPinOff, cpuVrefPinEnable, bank2RailLevel, railTestBit, railLevelLocked;
	int          errTotal = 0, totalChecks = 0, cyc = 0;
	mcr_config_regs dut (
		.clk_sys           (clk_sys),
		.srst              (srst),
		.resetByWatchdog   (resetByWatchdog),
		.regAddr           (regAddr),
		.regWrData         (regWrData),
		.regWr             (regWr),
		.regRd             (regRd),
		.regRdData         (regRdData),
		.bank2RailStrap    (bank2RailStrap),
		.watchdogFireTally (watchdogFireTally),
		.cpuVrefPinOff     (cpuVrefPinOff),
		.cpuVrefPinEnable  (cpuVrefPinEnable),
		.bank2RailLevel    (bank2RailLevel),
		.railTestBit       (railTestBit),
		.railLevelLocked   (railLevelLocked)
	);
	always #2 clk_sys = ~clk_sys;
	task conclude;
		$display("checks %0d errors %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	// Generous ceiling; the sequence needs under 200 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			errTotal++;
			conclude;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		totalChecks++;
		if (s !== e) begin
			errTotal++;
			$display("[ERR] t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr     <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
		#1;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		chk(regRdData, e);
	endtask : rd
	// Returns off the edge so outputs are settled when looked at
	task rst(input logic wd);
		@(posedge clk_sys);
		srst            <= 1'b1;
		resetByWatchdog <= wd;
		repeat (2) @(posedge clk_sys);
		srst            <= 1'b0;
		resetByWatchdog <= 1'b0;
		#1;
	endtask : rst
	initial begin
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		rd(8'h28, 32'h0);
		rd(8'h40, 32'h0);
		rd(8'h64, 32'h0);
		rd(8'h10, 32'h0);
		wr(8'h28, 32'hffff_ffff);
		rd(8'h28, 32'h0000_000f);
		wr(8'h28, 32'h0000_0005);
		wr(8'h40, 32'h1);
		chk({cpuVrefPinOff, cpuVrefPinEnable}, 32'h2);
		rst(1'b1);
		rd(8'h28, 32'h5);
		chk({cpuVrefPinOff, cpuVrefPinEnable}, 32'h1);
		wr(8'h28, 32'h6);
		rd(8'h28, 32'h6);
		rst(1'b0);
		chk(watchdogFireTally, 32'h0);
		wr(8'h64, 32'hffff_ff04);
		chk(bank2RailLevel, 32'h0);
		chk(railTestBit, 32'h0);
		rd(8'h64, 32'h4);
		wr(8'h64, 32'h0);
		rd(8'h64, 32'h0);
		wr(8'h64, 32'h6);
		rd(8'h64, 32'h6);
		chk(bank2RailLevel, 32'h1);
		rd(8'h68, 32'h1);
		@(posedge clk_sys);
		bank2RailStrap <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd(8'h68, 32'h2);
		wr(8'h64, 32'h82);
		chk(railLevelLocked, 32'h1);
		wr(8'h64, 32'h0);
		rd(8'h64, 32'h82);
		rst(1'b1);
		chk(railLevelLocked, 32'h0);
		rd(8'h64, 32'h0);
		conclude;
	end
endmodule : test_mcr_config_regs
`default_nettype wire
